// File: inc/rcs_pkg.sv
// Purpose: Constants and types shared by the reader command sequencer files
// Assumes: Register offsets are byte addresses on a 32-bit Avalon-MM slave
// Notes: Offsets of the register map are local to this block
package rcs_pkg;
   localparam int ADDR_W = 6;
   localparam logic [5:0] REG_CMD = 6'h00;
   localparam logic [5:0] REG_FRAMING = 6'h04;
   localparam logic [5:0] REG_MODE = 6'h08;
   localparam logic [5:0] REG_RXMODE = 6'h0C;
   localparam logic [5:0] REG_TEST = 6'h10;
   localparam logic [5:0] REG_ERR = 6'h14;
   localparam logic [5:0] REG_EVT = 6'h18;
   localparam logic [5:0] REG_STAT2 = 6'h1C;
   localparam logic [5:0] REG_CRC = 6'h20;
   localparam logic [5:0] REG_FIFO = 6'h24;
   localparam logic [5:0] REG_SRATE = 6'h28;
   // Command codes
   localparam logic [3:0] CMD_IDLE = 4'h0;
   localparam logic [3:0] CMD_MEM = 4'h1;
   localparam logic [3:0] CMD_RAND = 4'h2;
   localparam logic [3:0] CMD_CRC = 4'h3;
   localparam logic [3:0] CMD_TX = 4'h4;
   localparam logic [3:0] CMD_KEEP = 4'h7;
   localparam logic [3:0] CMD_RX = 4'h8;
   localparam logic [3:0] CMD_TRX = 4'hC;
   localparam logic [3:0] CMD_AUTH = 4'hE;
   localparam logic [3:0] CMD_SOFT = 4'hF;
   // Field positions
   localparam int CMD_PD_BIT = 4;
   localparam int CMD_RECEIVER_OFF_BIT_BIT = 5;
   localparam int LAUNCH_BIT = 7;
   localparam int MULTI_BIT = 2;
   localparam int ERR_PROT_BIT = 0;
   localparam int ERR_WR_BIT = 3;
   localparam int CIPHER_BIT = 3;
   localparam int EVT_TIMER_BIT = 0;
   localparam int EVT_IDLE_BIT = 4;
   localparam int EVT_RX_BIT = 5;
   localparam int EVT_TX_BIT = 6;
   // Reset values
   localparam logic [1:0] PRESET_RST = 2'h1;
   localparam logic [7:0] SRATE_RST = 8'hEB;
   // Counts
   localparam logic [4:0] MEM_BYTES = 5'h19;
   localparam logic [4:0] RAND_BYTES = 5'h0A;
   localparam logic [4:0] RAND_BASE = 5'h00;
   localparam logic [4:0] AUTH_BYTES = 5'h0C;
   localparam logic [4:0] TEST_BYTES = 5'h08;
   localparam logic [3:0] SELF_TEST_EN = 4'h9;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [15:0] CRC_PRESET0 = 16'h0000;
   localparam logic [15:0] CRC_PRESET1 = 16'h6363;
   localparam logic [15:0] CRC_PRESET2 = 16'hA671;
   localparam logic [15:0] CRC_PRESET3 = 16'hFFFF;
   typedef enum logic [3:0] {
      ST_IDLE, ST_MEM_IN, ST_MEM_OUT, ST_RAND, ST_CRC, ST_TEST,
      ST_TX, ST_TRX_WAIT, ST_RX, ST_AUTH_ARGS, ST_AUTH_RUN
   } rcs_state_t;
endpackage : rcs_pkg

// File: inc/rcs_mem_if.sv
// Purpose: Carrier between the sequencer and its byte buffer
// Assumes: One write port and one registered read port
// Notes: Controller drives all but rdata
`timescale 1ns/10ps
interface rcs_mem_if #(parameter int AW = 5, parameter int DW = 8);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : rcs_mem_if

// File: logic/rcs_buf_mem.sv
// Purpose: Internal byte buffer kept across every reset
// Assumes: Read data is registered, one cycle after the address
// Notes: No reset input, so contents survive hard and soft resets
`timescale 1ns/10ps
module rcs_buf_mem #(
   parameter int DEPTH = 25
) (
   input wire logic core_clk,
   rcs_mem_if.mem port
);
   logic [7:0] mem_q [DEPTH];

   always_ff @(posedge core_clk)
   begin
      if (port.we)
      begin
         mem_q[port.waddr] <= port.wdata;
      end
   end

   always_ff @(posedge core_clk)
   begin
      port.rdata <= mem_q[port.raddr];
   end
endmodule : rcs_buf_mem

// File: logic/rcs_sequencer.sv
// Purpose: Command sequencer of the reader with Avalon-MM register access
// Assumes: External FIFO with first-word-fall-through data and lagging flags
// Notes: FIFO flags are trusted only two cycles after our own pop or push
`timescale 1ns/10ps
module rcs_sequencer
   import rcs_pkg::*;
#(
   parameter int MEM_DEPTH = 25
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [7:0] fifo_rdata,
   input wire logic fifo_empty,
   input wire logic fifo_full,
   output logic fifo_pop,
   output logic fifo_push,
   output logic [7:0] fifo_wdata,
   output logic [7:0] tx_byte,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic rx_enable,
   input wire logic rx_frame_end,
   output logic [95:0] auth_key,
   output logic auth_start,
   input wire logic auth_ok,
   input wire logic auth_fail,
   input wire logic timer_expired,
   output logic power_down,
   output logic receiver_off,
   output logic [7:0] serial_rate
);
   rcs_state_t state_q, state_d;
   logic wait_q, pop_q, pop_hold_q, push_q, push_hold_q;
   logic [31:0] rdata_q;
   logic [3:0] code_q, selftest_q;
   logic pd_q, receiver_off_bit_q, launch_q, multi_q;
   logic [6:0] framing_q;
   logic [1:0] preset_q;
   logic [7:0] srate_q, wdata_q, tx_byte_q;
   logic wr_err_q, prot_err_q, cipher_q;
   logic ev_idle_q, ev_rx_q, ev_tx_q, ev_timer_q;
   logic [4:0] cnt_q;
   logic phase_q, tx_valid_q, rx_en_q, auth_start_q;
   logic [15:0] crc_q, lfsr_q;
   logic [95:0] key_q;
   logic acc, is_fifo, blocked, can_go, pop_ok, push_ok, fifo_busy;
   logic wr_cmd, cmd_start, soft_rst, srst;
   logic seq_pop, seq_push, host_pop, host_push, tx_drained;
   logic [7:0] seq_wdata;
   logic [31:0] rd_val;

   rcs_mem_if #(.AW(5), .DW(8)) mem_bus ();

   rcs_buf_mem #(.DEPTH(MEM_DEPTH)) u_mem (
      .core_clk(core_clk),
      .port(mem_bus.mem)
   );

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte

   function automatic logic [15:0] crc_preset(input logic [1:0] sel);
      logic [15:0] r;
      unique case (sel)
         2'h0: r = CRC_PRESET0;
         2'h1: r = CRC_PRESET1;
         2'h2: r = CRC_PRESET2;
         2'h3: r = CRC_PRESET3;
      endcase
      return r;
   endfunction : crc_preset

   // Bus handshake: request taken while waitrequest high, answered next cycle
   assign is_fifo = avs_address == REG_FIFO;
   assign blocked = state_q == ST_AUTH_ARGS || state_q == ST_AUTH_RUN;
   // A pop and a push can share a cycle; any pop or push leaves both flags stale for two cycles
   assign fifo_busy = pop_q || pop_hold_q || push_q || push_hold_q;
   assign pop_ok = !fifo_empty && !fifo_busy;
   assign push_ok = !fifo_full && !fifo_busy;
   assign wr_cmd = acc && avs_write && avs_address == REG_CMD;
   assign cmd_start = wr_cmd && avs_writedata[3:0] != CMD_KEEP;
   assign soft_rst = cmd_start && avs_writedata[3:0] == CMD_SOFT;
   assign srst = rst || soft_rst;
   assign tx_drained = fifo_empty && !pop_q && !pop_hold_q && !tx_valid_q;

   always_comb
   begin
      can_go = 1'b1;
      if (is_fifo && !blocked)
      begin
         if (avs_read)
         begin
            can_go = (fifo_empty && !fifo_busy) || (pop_ok && !seq_pop);
         end
         else
         begin
            can_go = (fifo_full && !fifo_busy) || (push_ok && !seq_push);
         end
      end
   end

   assign acc = (avs_read || avs_write) && wait_q && can_go;
   assign host_pop = acc && avs_read && is_fifo && !blocked && pop_ok;
   assign host_push = acc && avs_write && is_fifo && !blocked && push_ok;

   // FIFO use by the running command
   always_comb
   begin
      seq_pop = 1'b0;
      seq_push = 1'b0;
      seq_wdata = mem_bus.rdata;
      if (!cmd_start)
      begin
         unique case (state_q)
            ST_MEM_IN, ST_CRC, ST_AUTH_ARGS: seq_pop = pop_ok;
            ST_TX: seq_pop = pop_ok && (!tx_valid_q || tx_ready);
            ST_MEM_OUT: seq_push = push_ok && phase_q;
            ST_TEST:
            begin
               seq_push = push_ok;
               seq_wdata = crc_q[7:0];
            end
            default:
            begin
               seq_pop = 1'b0;
            end
         endcase
      end
   end

   // Command selection and termination
   always_comb
   begin
      state_d = state_q;
      if (cmd_start)
      begin
         unique case (avs_writedata[3:0])
            CMD_MEM: state_d = fifo_empty ? ST_MEM_OUT : ST_MEM_IN;
            CMD_RAND: state_d = ST_RAND;
            CMD_CRC: state_d = selftest_q == SELF_TEST_EN ? ST_TEST : ST_CRC;
            CMD_TX: state_d = ST_TX;
            CMD_RX: state_d = ST_RX;
            CMD_TRX: state_d = ST_TRX_WAIT;
            CMD_AUTH: state_d = ST_AUTH_ARGS;
            default: state_d = ST_IDLE;
         endcase
      end
      else
      begin
         unique case (state_q)
            ST_IDLE, ST_CRC: state_d = state_q;
            ST_MEM_IN: state_d = seq_pop && cnt_q == MEM_BYTES - 5'h01 ? ST_IDLE : state_q;
            ST_MEM_OUT: state_d = seq_push && cnt_q == MEM_BYTES - 5'h01 ? ST_IDLE : state_q;
            ST_RAND: state_d = cnt_q == RAND_BYTES - 5'h01 ? ST_IDLE : state_q;
            ST_TEST: state_d = seq_push && cnt_q == TEST_BYTES - 5'h01 ? ST_IDLE : state_q;
            ST_TX:
            begin
               if (tx_drained)
               begin
                  state_d = code_q == CMD_TRX ? ST_RX : ST_IDLE;
               end
            end
            ST_TRX_WAIT: state_d = launch_q ? ST_TX : state_q;
            ST_RX:
            begin
               if (rx_frame_end && !multi_q)
               begin
                  state_d = code_q == CMD_TRX ? ST_TRX_WAIT : ST_IDLE;
               end
            end
            ST_AUTH_ARGS: state_d = seq_pop && cnt_q == AUTH_BYTES - 5'h01 ? ST_AUTH_RUN : state_q;
            ST_AUTH_RUN: state_d = auth_ok || auth_fail ? ST_IDLE : state_q;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 5'h00;
         phase_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         if (state_d != state_q || cmd_start)
         begin
            cnt_q <= 5'h00;
            phase_q <= 1'b0;
         end
         else if (seq_pop || seq_push || state_q == ST_RAND)
         begin
            cnt_q <= 5'(cnt_q + 5'h01);
            phase_q <= 1'b0;
         end
         else if (state_q == ST_MEM_OUT && !phase_q)
         begin
            phase_q <= 1'b1;
         end
      end
   end

   // Buffer port: copy in, dump out, random fill
   always_comb
   begin
      mem_bus.raddr = cnt_q;
      mem_bus.we = 1'b0;
      mem_bus.waddr = cnt_q;
      mem_bus.wdata = fifo_rdata;
      if (state_q == ST_MEM_IN && seq_pop)
      begin
         mem_bus.we = 1'b1;
      end
      else if (state_q == ST_RAND && !cmd_start)
      begin
         mem_bus.we = 1'b1;
         mem_bus.waddr = 5'(RAND_BASE + cnt_q);
         mem_bus.wdata = lfsr_q[7:0];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         lfsr_q <= 16'hACE1;
      end
      else
      begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end

   // FIFO port, sequencer first; flags settle two cycles after a strobe
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         pop_q <= 1'b0;
         pop_hold_q <= 1'b0;
         push_q <= 1'b0;
         push_hold_q <= 1'b0;
         wdata_q <= 8'h00;
      end
      else
      begin
         pop_q <= seq_pop || host_pop;
         pop_hold_q <= pop_q;
         push_q <= seq_push || host_push;
         push_hold_q <= push_q;
         if (seq_push)
         begin
            wdata_q <= seq_wdata;
         end
         else if (host_push)
         begin
            wdata_q <= avs_writedata[7:0];
         end
      end
   end

   // Datapath of transmit, receive, CRC and authentication
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         tx_valid_q <= 1'b0;
         tx_byte_q <= 8'h00;
         rx_en_q <= 1'b0;
         crc_q <= 16'h0000;
         key_q <= '0;
         auth_start_q <= 1'b0;
      end
      else
      begin
         if (cmd_start)
         begin
            tx_valid_q <= 1'b0;
         end
         else if (state_q == ST_TX && seq_pop)
         begin
            tx_byte_q <= fifo_rdata;
            tx_valid_q <= 1'b1;
         end
         else if (tx_ready)
         begin
            tx_valid_q <= 1'b0;
         end
         rx_en_q <= state_d == ST_RX;
         if (cmd_start && avs_writedata[3:0] == CMD_CRC)
         begin
            crc_q <= crc_preset(preset_q);
         end
         else if (state_q == ST_CRC && seq_pop)
         begin
            crc_q <= crc_byte(crc_q, fifo_rdata);
         end
         else if (state_q == ST_TEST && seq_push)
         begin
            crc_q <= crc_byte(crc_q, {3'h0, cnt_q});
         end
         if (state_q == ST_AUTH_ARGS && seq_pop)
         begin
            key_q <= {key_q[87:0], fifo_rdata};
         end
         auth_start_q <= state_q == ST_AUTH_ARGS && state_d == ST_AUTH_RUN;
      end
   end

   // Software-written configuration
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         code_q <= CMD_IDLE;
         pd_q <= 1'b0;
         receiver_off_bit_q <= 1'b0;
         framing_q <= 7'h00;
         launch_q <= 1'b0;
         preset_q <= PRESET_RST;
         multi_q <= 1'b0;
         selftest_q <= 4'h0;
         srate_q <= SRATE_RST;
      end
      else
      begin
         if (wr_cmd)
         begin
            pd_q <= avs_writedata[CMD_PD_BIT];
            receiver_off_bit_q <= avs_writedata[CMD_RECEIVER_OFF_BIT_BIT];
         end
         if (cmd_start)
         begin
            code_q <= avs_writedata[3:0];
         end
         else if (state_d == ST_IDLE)
         begin
            code_q <= CMD_IDLE;
         end
         if (acc && avs_write && avs_address == REG_FRAMING)
         begin
            framing_q <= avs_writedata[6:0];
            launch_q <= avs_writedata[LAUNCH_BIT] | (launch_q && state_q != ST_TRX_WAIT);
         end
         else if (state_q == ST_TRX_WAIT && !cmd_start)
         begin
            launch_q <= 1'b0;
         end
         if (acc && avs_write && avs_address == REG_MODE)
         begin
            preset_q <= avs_writedata[1:0];
         end
         if (acc && avs_write && avs_address == REG_RXMODE)
         begin
            multi_q <= avs_writedata[MULTI_BIT];
         end
         if (acc && avs_write && avs_address == REG_TEST)
         begin
            selftest_q <= avs_writedata[3:0];
         end
         if (acc && avs_write && avs_address == REG_SRATE)
         begin
            srate_q <= avs_writedata[7:0];
         end
      end
   end

   // Sticky flags: hardware set wins over a write-one clear
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         wr_err_q <= 1'b0;
         prot_err_q <= 1'b0;
         cipher_q <= 1'b0;
         ev_idle_q <= 1'b0;
         ev_rx_q <= 1'b0;
         ev_tx_q <= 1'b0;
         ev_timer_q <= 1'b0;
      end
      else
      begin
         if (acc && is_fifo && blocked)
         begin
            wr_err_q <= 1'b1;
         end
         else if (acc && avs_write && is_fifo && fifo_full)
         begin
            wr_err_q <= 1'b1;
         end
         else if (acc && avs_write && avs_address == REG_ERR && avs_writedata[ERR_WR_BIT])
         begin
            wr_err_q <= 1'b0;
         end
         if (state_q == ST_AUTH_RUN && auth_fail && !cmd_start)
         begin
            prot_err_q <= 1'b1;
         end
         else if (acc && avs_write && avs_address == REG_ERR && avs_writedata[ERR_PROT_BIT])
         begin
            prot_err_q <= 1'b0;
         end
         if (state_q == ST_AUTH_RUN && !cmd_start && (auth_ok || auth_fail))
         begin
            cipher_q <= auth_ok;
         end
         else if (acc && avs_write && avs_address == REG_STAT2)
         begin
            cipher_q <= avs_writedata[CIPHER_BIT];
         end
         ev_idle_q <= (state_q != ST_IDLE && state_d == ST_IDLE)
            || (ev_idle_q && !(acc && avs_write && avs_address == REG_EVT
            && avs_writedata[EVT_IDLE_BIT]));
         // Authentication states never reach the rx and tx terms; the timer event is set in any state
         ev_rx_q <= (state_q == ST_RX && rx_frame_end && !cmd_start)
            || (ev_rx_q && !(acc && avs_write && avs_address == REG_EVT
            && avs_writedata[EVT_RX_BIT]));
         ev_tx_q <= (state_q == ST_TX && tx_drained && !cmd_start)
            || (ev_tx_q && !(acc && avs_write && avs_address == REG_EVT
            && avs_writedata[EVT_TX_BIT]));
         ev_timer_q <= timer_expired
            || (ev_timer_q && !(acc && avs_write && avs_address == REG_EVT
            && avs_writedata[EVT_TIMER_BIT]));
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rd_val = 32'h0000_0000;
      unique case (avs_address)
         REG_CMD: rd_val = {26'h0, receiver_off_bit_q, pd_q, code_q};
         REG_FRAMING: rd_val = {24'h0, launch_q, framing_q};
         REG_MODE: rd_val = {30'h0, preset_q};
         REG_RXMODE: rd_val = {29'h0, multi_q, 2'h0};
         REG_TEST: rd_val = {28'h0, selftest_q};
         REG_ERR: rd_val = {28'h0, wr_err_q, 2'h0, prot_err_q};
         REG_EVT: rd_val = {25'h0, ev_tx_q, ev_rx_q, ev_idle_q, 3'h0, ev_timer_q};
         REG_STAT2: rd_val = {28'h0, cipher_q, 3'h0};
         REG_CRC: rd_val = {16'h0, crc_q};
         REG_FIFO: rd_val = host_pop ? {24'h0, fifo_rdata} : 32'h0000_0000;
         REG_SRATE: rd_val = {24'h0, srate_q};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         wait_q <= !acc;
         if (acc && avs_read)
         begin
            rdata_q <= rd_val;
         end
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign fifo_pop = pop_q;
   assign fifo_push = push_q;
   assign fifo_wdata = wdata_q;
   assign tx_byte = tx_byte_q;
   assign tx_valid = tx_valid_q;
   assign rx_enable = rx_en_q;
   assign auth_key = key_q;
   assign auth_start = auth_start_q;
   assign power_down = pd_q;
   assign receiver_off = receiver_off_bit_q;
   assign serial_rate = srate_q;
endmodule : rcs_sequencer

// File: tb/rcs_sequencer_properties.sv
// Purpose: Port timing checks of the sequencer
// Assumes: One clock, synchronous reset
// Notes: Bound to every sequencer instance
`timescale 1ns/10ps
module rcs_sequencer_properties
   import rcs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic fifo_pop,
   input wire logic fifo_push,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic rx_enable,
   input wire logic auth_start,
   input wire logic [7:0] serial_rate
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (rst);
   sequence s_taken;
      avs_write && avs_waitrequest && avs_address == REG_CMD;
   endsequence
   sequence s_quiet;
      !rx_enable && !tx_valid && !auth_start;
   endsequence
   AST_ANSWER: assert property (
      (avs_read || avs_write) && avs_waitrequest |-> ##[1:40] !avs_waitrequest)
      else $error("bus request not answered");
   AST_IDLE: assert property (
      s_taken ##0 avs_writedata[3:0] inside {4'h0, 4'h5, 4'h6, 4'hD} |-> ##[1:4] s_quiet)
      else $error("idle write left activity");
   AST_SOFT: assert property (
      s_taken ##0 avs_writedata[3:0] == CMD_SOFT |-> ##[1:3] serial_rate == SRATE_RST)
      else $error("soft reset missed rate");
   AST_GAP: assert property (
      (fifo_pop || fifo_push) |=> (!fifo_pop && !fifo_push) [*2])
      else $error("fifo strobes too close");
   AST_ARGS: assert property (auth_start |-> fifo_pop)
      else $error("auth started before last byte");
   AST_BLOCK: assert property (
      auth_start |=> (!fifo_pop && !fifo_push) [*8])
      else $error("fifo touched during auth");
   AST_PULSE: assert property (auth_start |=> !auth_start)
      else $error("auth start not a pulse");
   AST_TXHOLD: assert property (
      tx_valid && !tx_ready && !avs_write && !$past(avs_write) |=> tx_valid && $stable(tx_byte))
      else $error("tx byte dropped");
endmodule : rcs_sequencer_properties
bind rcs_sequencer rcs_sequencer_properties prop_u (.core_clk, .rst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_waitrequest, .fifo_pop, .fifo_push, .tx_byte, .tx_valid,
   .tx_ready, .rx_enable, .auth_start, .serial_rate);

// File: tb/rcs_fifo_model.sv
// Purpose: Byte FIFO beside the sequencer
// Assumes: Fall-through head, flags follow each edge
// Notes: Empty head shows the inverse of the last byte
`timescale 1ns/10ps
module rcs_fifo_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pop,
   input wire logic push,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic empty,
   output logic full
);
   logic [7:0] q [$];
   logic [7:0] last_q = 8'h00;
   initial {rdata, empty, full} = 10'h002;
   always @(posedge core_clk)
   begin
      if (rst)
         q.delete();
      if (!rst && pop && q.size() > 0)
         last_q = q.pop_front();
      if (!rst && push && q.size() < 64)
         q.push_back(wdata);
      rdata <= (q.size() > 0) ? q[0] : ~last_q;
      empty <= (q.size() == 0);
      full <= (q.size() == 64);
   end
endmodule : rcs_fifo_model

// File: tb/rcs_sequencer_test.sv
// Purpose: Self-checking bench of the sequencer
// Assumes: FIFO model on the byte side
// Notes: Register rows first, commands after
`timescale 1ns/10ps
module rcs_sequencer_test
   import rcs_pkg::*;
;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic avs_read = 1'h0, avs_write = 1'h0, tx_ready = 1'h0, rx_frame_end = 1'h0;
   logic auth_ok = 1'h0, auth_fail = 1'h0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdq;
   logic avs_waitrequest, fifo_empty, fifo_full, fifo_pop, fifo_push, tx_valid, rx_enable;
   logic auth_start, power_down, receiver_off;
   logic [7:0] fifo_rdata, fifo_wdata, tx_byte;
   logic [95:0] auth_key, ek = 96'h0;
   int miscompares = 0, num_checks = 0, ntx = 0, i;
   logic [37:0] rows [4] = '{{REG_CMD, 32'h0}, {REG_MODE, 32'h1}, {REG_SRATE, 32'hEB},
      {6'h2C, 32'h0}};
   rcs_sequencer dut_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .fifo_rdata, .fifo_empty, .fifo_full, .fifo_pop,
      .fifo_push, .fifo_wdata, .tx_byte, .tx_valid, .tx_ready, .rx_enable, .rx_frame_end,
      .auth_key, .auth_start, .auth_ok, .auth_fail, .timer_expired(1'h0), .power_down,
      .receiver_off, .serial_rate());
   rcs_fifo_model fifo_u (.core_clk, .rst, .pop(fifo_pop), .push(fifo_push),
      .wdata(fifo_wdata), .rdata(fifo_rdata), .empty(fifo_empty), .full(fifo_full));
   initial forever #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) tx_ready <= ~tx_ready;
   always @(posedge core_clk)
      ntx += (tx_valid === 1'h1 && tx_ready === 1'h1 && tx_byte === 8'h55);
   task automatic chk(input logic [31:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'h0);
      rdq = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask : bus
   task automatic wait_idle;
      bus(1'h0, REG_CMD, 32'h0);
      for (int k = 0; k < 200 && rdq[3:0] !== CMD_IDLE; k++)
         bus(1'h0, REG_CMD, 32'h0);
      chk(rdq[3:0], CMD_IDLE);
   endtask : wait_idle
   task automatic readback(input int lo);
      for (int j = 0; j < 25; j++)
      begin
         bus(1'h0, REG_FIFO, 32'h0);
         if (j >= lo)
            chk(rdq, 32'hA0 ^ j);
      end
   endtask : readback
   task automatic auth(input logic [7:0] code, input logic ok);
      for (int j = 0; j < 12; j++)
      begin
         ek = {ek[87:0], (j == 0) ? code : 8'h20 + 8'(j)};
         bus(1'h1, REG_FIFO, {24'h0, ek[7:0]});
      end
      bus(1'h1, REG_CMD, {28'h0, CMD_AUTH});
      for (int k = 0; k < 300 && auth_start !== 1'h1; k++)
         @(posedge core_clk);
      chk(auth_key === ek, 32'h1);
      bus(1'h0, REG_FIFO, 32'h0);
      auth_ok <= ok;
      auth_fail <= ~ok;
      @(posedge core_clk);
      auth_ok <= 1'h0;
      auth_fail <= 1'h0;
      wait_idle();
      bus(1'h0, REG_STAT2, 32'h0);
      chk(rdq[CIPHER_BIT], ok);
      bus(1'h0, REG_ERR, 32'h0);
      chk(rdq[3:0], {1'h1, 2'h0, ~ok});
      bus(1'h1, REG_ERR, 32'h9);
   endtask : auth
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   initial
   begin
      #200000;
      miscompares++;
      conclude();
   end
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst <= 1'h0;
      foreach (rows[r])
      begin
         bus(1'h0, rows[r][37:32], 32'h0);
         chk(rdq, rows[r][31:0]);
      end
      for (i = 0; i < 25; i++)
         bus(1'h1, REG_FIFO, 32'hA0 ^ i);
      bus(1'h1, REG_CMD, {28'h0, CMD_MEM});
      wait_idle();
      rst <= 1'h1;
      repeat (3) @(posedge core_clk);
      rst <= 1'h0;
      bus(1'h1, REG_CMD, {28'h0, CMD_MEM});
      wait_idle();
      readback(0);
      bus(1'h1, REG_CMD, {28'h0, CMD_RAND});
      wait_idle();
      bus(1'h1, REG_CMD, {28'h0, CMD_MEM});
      wait_idle();
      readback(10);
      $display("buffer test done");
      bus(1'h1, REG_MODE, 32'h3);
      bus(1'h1, REG_FIFO, 32'h12);
      bus(1'h1, REG_CMD, {28'h0, CMD_CRC});
      bus(1'h1, REG_CMD, 32'h37);
      chk({power_down, receiver_off}, 32'h3);
      bus(1'h1, REG_FIFO, 32'h34);
      ek[15:0] = CRC_PRESET3;
      for (i = 0; i < 16; i++)
         ek[15:0] = (ek[0] ^ ((i < 8) ? 8'h12 >> i : 8'h34 >> (i - 8)) & 1'h1) ?
            (ek[15:0] >> 1) ^ CRC_POLY : ek[15:0] >> 1;
      for (i = 0; i < 50 && rdq[15:0] !== ek[15:0]; i++)
         bus(1'h0, REG_CRC, 32'h0);
      chk(rdq, {16'h0, ek[15:0]});
      bus(1'h1, REG_CMD, 32'h5);
      wait_idle();
      bus(1'h1, REG_TEST, {28'h0, SELF_TEST_EN});
      bus(1'h1, REG_CMD, {28'h0, CMD_CRC});
      wait_idle();
      chk(fifo_empty, 1'h0);
      bus(1'h1, REG_TEST, 32'h0);
      readback(25);
      ntx = 0;
      for (i = 0; i < 3; i++)
         bus(1'h1, REG_FIFO, 32'h55);
      bus(1'h1, REG_CMD, {28'h0, CMD_TX});
      wait_idle();
      chk(ntx, 32'h3);
      bus(1'h1, REG_CMD, {28'h0, CMD_RX});
      chk(rx_enable, 1'h1);
      rx_frame_end <= 1'h1;
      @(posedge core_clk);
      rx_frame_end <= 1'h0;
      wait_idle();
      ntx = 0;
      bus(1'h1, REG_FIFO, 32'h55);
      bus(1'h1, REG_CMD, {28'h0, CMD_TRX});
      chk(ntx, 32'h0);
      bus(1'h1, REG_FRAMING, 32'h80);
      for (i = 0; i < 50 && rx_enable !== 1'h1; i++)
         @(posedge core_clk);
      chk(ntx, 32'h1);
      bus(1'h1, REG_RXMODE, 32'h4);
      rx_frame_end <= 1'h1;
      @(posedge core_clk);
      rx_frame_end <= 1'h0;
      repeat (2) @(posedge core_clk);
      chk(rx_enable, 1'h1);
      bus(1'h1, REG_CMD, {28'h0, CMD_IDLE});
      chk(rx_enable, 1'h0);
      auth(8'h60, 1'h1);
      auth(8'h61, 1'h0);
      $display("auth test done");
      bus(1'h1, REG_SRATE, 32'h55);
      bus(1'h1, REG_CMD, {28'h0, CMD_SOFT});
      bus(1'h0, REG_MODE, 32'h0);
      chk(rdq, 32'h1);
      bus(1'h0, REG_SRATE, 32'h0);
      chk(rdq, {24'h0, SRATE_RST});
      conclude();
   end
endmodule : rcs_sequencer_test
